// ===== logic_cluster_map.svh
`ifndef LOGIC_CLUSTER_MAP_SVH
`define LOGIC_CLUSTER_MAP_SVH

// cluster geometry
`define LC_CELLS        10
`define LC_EXT_INPUTS   26
`define LC_COL_CLOCKS   4
`define LC_LOCAL_LINES  56
`define LC_CTRL_NUM     10

// line select code space: column clocks first, then local lines
`define LC_LINE_BASE    6'h04
`define LC_LINE_LIMIT   6'h38

// positions of the cluster-wide controls in the control vector
`define LC_IX_CLK0      0
`define LC_IX_CLK1      1
`define LC_IX_ENA0      2
`define LC_IX_ENA1      3
`define LC_IX_ACLR0     4
`define LC_IX_ACLR1     5
`define LC_IX_SCLR      6
`define LC_IX_ALOAD     7
`define LC_IX_SLOAD     8
`define LC_IX_ADDNSUB   9

// value of a control that no source drives (gates open, rest idle)
`define LC_CTRL_IDLE    10'h00C

// reset values
`define LC_RST_BIT      1'b0
`define LC_RST_COUNT    4'h0

`endif

// ===== logic_cluster_pkg.sv
package logic_cluster_pkg;

  // code picking a column clock or one local interconnect line
  typedef logic [5:0] line_sel_t;

  // four-input lookup contents, indexed by {d3,d2,d1,d0}
  typedef logic [15:0] lut_mask_t;

endpackage

// ===== logic_cluster_cell.sv
`timescale 1ns/100ps
`include "logic_cluster_map.svh"

module logic_cluster_cell
(
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire logic [3:0]                  data_i,
  input  wire logic_cluster_pkg::lut_mask_t mask_i,
  input  wire logic                        arith_i,
  input  wire logic                        addnsub_i,
  input  wire logic                        carry_i,
  input  wire logic                        chain_i,
  input  wire logic                        reg_chain_i,
  input  wire logic                        edge_i,
  input  wire logic                        aclr_i,
  input  wire logic                        aload_i,
  input  wire logic                        sclr_i,
  input  wire logic                        sload_i,
  input  wire logic                        preset_i,
  input  wire logic                        push_back_i,
  output logic                             lut_o,
  output logic                             carry_o,
  output logic                             q_o
);

  logic stored;
  logic next_stored;
  logic inv;
  logic load_one;
  logic op_a;
  logic op_b;
  logic d_true;
  logic adata;

  //////////////////////////////////////////////////////////////////////////
  // lookup and arithmetic path
  always_comb
  begin
    op_a    = data_i[0];
    op_b    = data_i[1] ^ addnsub_i;
    if (arith_i)
    begin
      lut_o   = op_a ^ op_b ^ carry_i;
      carry_o = (op_a & op_b) | (carry_i & (op_a ^ op_b));
    end
    else
    begin
      lut_o   = mask_i[data_i];
      carry_o = carry_i;      // carry ripples past a non-arith cell
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register with preset by inversion or by async load of one
  always_comb
  begin
    inv      = preset_i & push_back_i;
    load_one = preset_i & ~push_back_i;
    adata    = load_one ? 1'b1 : data_i[3];
    d_true   = reg_chain_i ? chain_i : lut_o;
    next_stored = stored;
    if (aclr_i)
      next_stored = 1'b0;     // stored zero reads back as preset value only under push-back inversion
    else if (aload_i)
      next_stored = adata ^ inv;
    else if (edge_i)
    begin
      if (sclr_i)
        next_stored = 1'b0;
      else if (sload_i)
        next_stored = adata ^ inv;
      else
        next_stored = d_true ^ inv;
    end
    q_o = stored ^ inv;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      stored <= `LC_RST_BIT;
    else
      stored <= next_stored;
  end

endmodule // logic_cluster_cell

// ===== logic_cluster.sv
`timescale 1ns/100ps
`include "logic_cluster_map.svh"

module logic_cluster
(
  input  wire logic                                   clk_i,
  input  wire logic                                   resetn_i,
  input  wire logic [`LC_COL_CLOCKS-1:0]              col_clk_i,
  input  wire logic [`LC_EXT_INPUTS-1:0]              ext_in_i,
  input  wire logic [`LC_CELLS-1:0]                   left_link_i,
  input  wire logic [`LC_CELLS-1:0]                   right_link_i,
  input  wire logic_cluster_pkg::line_sel_t [`LC_CTRL_NUM-1:0] ctrl_sel_i,
  input  wire logic [`LC_CTRL_NUM-1:0]                ctrl_use_i,
  input  wire logic [1:0]                             clk_fall_i,
  input  wire logic                                   push_back_en_i,
  input  wire logic_cluster_pkg::lut_mask_t [`LC_CELLS-1:0] lut_mask_i,
  input  wire logic_cluster_pkg::line_sel_t [`LC_CELLS-1:0][3:0] data_sel_i,
  input  wire logic [`LC_CELLS-1:0]                   cell_clk_pick_i,
  input  wire logic [`LC_CELLS-1:0]                   cell_clr_pick_i,
  input  wire logic [`LC_CELLS-1:0]                   cell_arith_i,
  input  wire logic [`LC_CELLS-1:0]                   cell_lut_chain_i,
  input  wire logic [`LC_CELLS-1:0]                   cell_reg_chain_i,
  input  wire logic [`LC_CELLS-1:0]                   cell_preset_i,
  input  wire logic [`LC_CELLS-1:0]                   cell_use_reg_i,
  output logic [1:0]                                  cluster_clk_o,
  output logic [`LC_CELLS-1:0]                        cell_comb_o,
  output logic [`LC_CELLS-1:0]                        cell_reg_o,
  output logic [`LC_CELLS-1:0]                        link_out_o,
  output logic                                        carry_out_o,
  output logic [3:0]                                  active_ctrl_o
);

  logic [`LC_LOCAL_LINES-1:0] local_line;
  logic [`LC_CTRL_NUM-1:0]    ctrl;
  logic [1:0]                 src_prev;
  logic [1:0]                 next_src_prev;
  logic [1:0]                 gate;
  logic [1:0]                 next_gate;
  logic [1:0]                 next_cluster_clk;
  logic [1:0]                 inactive;
  logic [1:0]                 edge_raw;
  logic [1:0]                 edge_gated;
  logic [3:0]                 next_active;
  logic [`LC_CELLS-1:0]       cell_lut;
  logic [`LC_CELLS-1:0]       cell_q;
  logic [`LC_CELLS-1:0]       edge_cell;
  logic [`LC_CELLS-1:0]       aclr_cell;
  logic [`LC_CELLS:0]         carry;
  logic [`LC_CELLS:0]         lut_chain;
  logic [`LC_CELLS:0]         reg_chain;
  logic [`LC_CELLS-1:0][3:0]  cell_data;
  logic [`LC_CELLS-1:0]       next_comb;
  logic [`LC_CELLS-1:0]       next_link;
  logic [`LC_CELLS-1:0]       next_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // code 0..3 is a column clock, then the local lines, else low
  function automatic logic pick_line
  (
    input logic_cluster_pkg::line_sel_t s,
    input logic [`LC_COL_CLOCKS-1:0]    col,
    input logic [`LC_LOCAL_LINES-1:0]   loc
  );
    logic [5:0] k;
    k = s - `LC_LINE_BASE;
    if (s < `LC_LINE_BASE)
      return col[s[1:0]];
    else if (k < `LC_LINE_LIMIT)
      return loc[k];
    else
      return 1'b0;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // local interconnect; feedback taken from flops so no loop can form
  assign local_line = {right_link_i, left_link_i,
                       link_out_o, ext_in_i};

  //////////////////////////////////////////////////////////////////////////
  // cluster-wide controls from column clocks or local lines
  genvar k;
  generate
    for (k = 0; k < `LC_CTRL_NUM; k++)
    begin : g_ctrl
      assign ctrl[k] = ctrl_use_i[k] ?
                       pick_line(ctrl_sel_i[k], col_clk_i, local_line) :
                       1'(`LC_CTRL_IDLE >> k);
    end
  endgenerate

  // count of controls in use, never above ten by construction
  always_comb
  begin
    next_active = `LC_RST_COUNT;
    for (int j = 0; j < `LC_CTRL_NUM; j++)
      next_active = next_active + {3'h0, ctrl_use_i[j]};
  end

  //////////////////////////////////////////////////////////////////////////
  // clock edge detect and glitch-free gating per cluster clock
  always_comb
  begin
    for (int j = 0; j < 2; j++)
    begin
      // inactive: low for a rising clock, high for a falling one
      inactive[j] = (ctrl[j] == clk_fall_i[j]);
      next_gate[j] = inactive[j] ? ctrl[`LC_IX_ENA0 + j]
                                 : gate[j];
      edge_raw[j] = clk_fall_i[j] ? (src_prev[j] & ~ctrl[j])
                                  : (~src_prev[j] & ctrl[j]);
      edge_gated[j] = edge_raw[j] & gate[j];
      // a closed gate parks the clock at its inactive level
      next_cluster_clk[j] = gate[j] ? ctrl[j] : clk_fall_i[j];
      next_src_prev[j] = ctrl[j];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      src_prev      <= 2'h0;
      gate          <= 2'h0;
      cluster_clk_o <= 2'h0;
      active_ctrl_o <= `LC_RST_COUNT;
    end
    else
    begin
      src_prev      <= next_src_prev;
      gate          <= next_gate;
      cluster_clk_o <= next_cluster_clk;
      active_ctrl_o <= next_active;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ten cells with carry, lookup and register chains
  assign carry[0]     = ctrl[`LC_IX_ADDNSUB];
  assign lut_chain[0] = 1'b0;
  assign reg_chain[0] = 1'b0;

  genvar i;
  generate
    for (i = 0; i < `LC_CELLS; i++)
    begin : g_cell
      assign cell_data[i][2:0] = {
        pick_line(data_sel_i[i][2], col_clk_i, local_line),
        pick_line(data_sel_i[i][1], col_clk_i, local_line),
        pick_line(data_sel_i[i][0], col_clk_i, local_line)};
      assign cell_data[i][3] = cell_lut_chain_i[i] ? lut_chain[i] :
        pick_line(data_sel_i[i][3], col_clk_i, local_line);
      assign edge_cell[i] = cell_clk_pick_i[i] ? edge_gated[1]
                                               : edge_gated[0];
      assign aclr_cell[i] = cell_clr_pick_i[i] ? ctrl[`LC_IX_ACLR1]
                                               : ctrl[`LC_IX_ACLR0];
      assign lut_chain[i+1] = cell_lut[i];
      assign reg_chain[i+1] = cell_q[i];

      logic_cluster_cell u_cell
      (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .data_i      (cell_data[i]),
        .mask_i      (lut_mask_i[i]),
        .arith_i     (cell_arith_i[i]),
        .addnsub_i   (ctrl[`LC_IX_ADDNSUB]),
        .carry_i     (carry[i]),
        .chain_i     (reg_chain[i]),
        .reg_chain_i (cell_reg_chain_i[i]),
        .edge_i      (edge_cell[i]),
        .aclr_i      (aclr_cell[i]),
        .aload_i     (ctrl[`LC_IX_ALOAD]),
        .sclr_i      (ctrl[`LC_IX_SCLR]),
        .sload_i     (ctrl[`LC_IX_SLOAD]),
        .preset_i    (cell_preset_i[i]),
        .push_back_i (push_back_en_i),
        .lut_o       (cell_lut[i]),
        .carry_o     (carry[i+1]),
        .q_o         (cell_q[i])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // output flops; costs one cycle but keeps every pin registered
  always_comb
  begin
    next_comb = cell_lut;
    next_reg  = cell_q;
    next_link = (cell_q & cell_use_reg_i) |
                (cell_lut & ~cell_use_reg_i);
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cell_comb_o <= 10'h000;
      cell_reg_o  <= 10'h000;
      link_out_o  <= 10'h000;
      carry_out_o <= `LC_RST_BIT;
    end
    else
    begin
      cell_comb_o <= next_comb;
      cell_reg_o  <= next_reg;
      link_out_o  <= next_link;
      carry_out_o <= carry[`LC_CELLS];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence active_phase0;
    ctrl[0] != clk_fall_i[0];
  endsequence

  gate_change_a: assert property (
    (gate[0] != $past(gate[0])) |-> $past(ctrl[0] == clk_fall_i[0]))
    else $error("gate changed during active clock phase");

  gate_stable_a: assert property (
    active_phase0 ##1 active_phase0 |-> $stable(gate[0]))
    else $error("gate moved while clock held active");

  clock_stop_a: assert property (
    !gate[0] |=> cluster_clk_o[0] == $past(clk_fall_i[0]))
    else $error("gated cluster clock still toggles");

  edge_pol_a: assert property (
    edge_gated[1] |-> gate[1] && ctrl[1] != clk_fall_i[1])
    else $error("edge taken at wrong polarity");

  ctrl_count_a: assert property (
    active_ctrl_o <= 4'hA)
    else $error("more than ten controls active");

  add_sum_a: assert property (
    cell_arith_i[0] && !ctrl[`LC_IX_ADDNSUB] |=>
    cell_comb_o[0] == ($past(cell_data[0][0]) ^ $past(cell_data[0][1])))
    else $error("add result wrong");

  sub_seed_a: assert property (
    cell_arith_i[0] && ctrl[`LC_IX_ADDNSUB] &&
    cell_data[0][0] == cell_data[0][1] |=> cell_comb_o[0] == 1'b0)
    else $error("a minus a not zero");

  reg_chain_a: assert property (
    edge_cell[1] && cell_reg_chain_i[1] && !aclr_cell[1] &&
    !ctrl[`LC_IX_ALOAD] && !ctrl[`LC_IX_SCLR] && !ctrl[`LC_IX_SLOAD] &&
    !cell_preset_i[1] |=> cell_q[1] == $past(cell_q[0]))
    else $error("register chain not followed");

  push_back_a: assert property (
    aclr_cell[0] && cell_preset_i[0] && push_back_en_i ##1
    cell_preset_i[0] && push_back_en_i |-> cell_q[0])
    else $error("clear did not preset");

  aload_one_a: assert property (
    ctrl[`LC_IX_ALOAD] && !aclr_cell[0] && cell_preset_i[0] &&
    !push_back_en_i |=> cell_q[0] || push_back_en_i)
    else $error("async load preset failed");

  gate_hold_a: assert property (
    !edge_cell[0] && !aclr_cell[0] && !ctrl[`LC_IX_ALOAD] &&
    !cell_preset_i[0] |=> $stable(cell_q[0]) || cell_preset_i[0])
    else $error("register moved without its clock");

endmodule // logic_cluster

// ===== cluster_neighbours.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
// far side: column clock lines and neighbour cluster links
module cluster_neighbours
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       run_i,
  output logic [3:0]      col_clk_o,
  output logic [9:0]      left_o,
  output logic [9:0]      right_o
);
  logic [3:0] cnt;

  // column lines stand still unless run; links change every cycle so
  // a stale sample never passes for a fresh one
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt     <= 4'h0;
      left_o  <= 10'h155;
      right_o <= 10'h0F0;
    end
    else
    begin
      cnt     <= run_i ? cnt + 4'h1 : cnt;
      left_o  <= ~left_o;
      right_o <= {right_o[8:0], ~right_o[9]};
    end
  end

  // four lines at halving rates, line 0 toggles each cycle
  assign col_clk_o = cnt;
endmodule // cluster_neighbours

// ===== tb_top.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
module tb_top;
  logic                                       clk;
  logic                                       resetn;
  logic                                       run;
  logic [25:0]                                ext;
  logic_cluster_pkg::line_sel_t [9:0]         csel;
  logic [9:0]                                 cuse;
  logic_cluster_pkg::lut_mask_t [9:0]         mask;
  logic_cluster_pkg::line_sel_t [9:0][3:0]    dsel;
  logic [9:0]                                 arith;
  logic [9:0]                                 rchain;
  logic [9:0]                                 preset;
  logic [9:0]                                 ureg;
  logic [3:0]                                 col;
  logic [9:0]                                 lnk_l;
  logic [9:0]                                 lnk_r;
  logic [1:0]                                 cclk;
  logic [9:0]                                 comb;
  logic [9:0]                                 regq;
  logic [9:0]                                 link;
  logic                                       cout;
  logic [3:0]                                 act;
  int                                         mismatches;
  int                                         checked;
  int                                         seed;
  int                                         k [10][4];
  logic [25:0]                                e;
  logic [9:0]                                 cu;
  logic [9:0]                                 a;
  logic [9:0]                                 b;
  logic [10:0]                                sum;
  logic [9:0]                                 want;
  logic [3:0]                                 ix;
  int                                         cnt;
  logic [1:0]                                 fall;
  logic                                       pb;
  logic [9:0]                                 pick;
  logic [9:0]                                 lchain;

  // free clock at 100 MHz
  always #5 clk = ~clk;

  cluster_neighbours cluster_neighbours_inst
  (
    .clk_i(clk), .resetn_i(resetn), .run_i(run),
    .col_clk_o(col), .left_o(lnk_l), .right_o(lnk_r)
  );

  // only the clear pair pick stays fixed
  logic_cluster logic_cluster_inst
  (
    .clk_i(clk), .resetn_i(resetn), .col_clk_i(col), .ext_in_i(ext),
    .left_link_i(lnk_l), .right_link_i(lnk_r), .ctrl_sel_i(csel),
    .ctrl_use_i(cuse), .clk_fall_i(fall), .push_back_en_i(pb),
    .lut_mask_i(mask), .data_sel_i(dsel), .cell_clk_pick_i(pick),
    .cell_clr_pick_i(10'h000), .cell_arith_i(arith),
    .cell_lut_chain_i(lchain), .cell_reg_chain_i(rchain),
    .cell_preset_i(preset), .cell_use_reg_i(ureg),
    .cluster_clk_o(cclk), .cell_comb_o(comb), .cell_reg_o(regq),
    .link_out_o(link), .carry_out_o(cout), .active_ctrl_o(act)
  );

  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task conclude;
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reference: local line index 26 stands for a code that reads 0
  function automatic logic line_val(int kk, logic [25:0] x);
    return (kk == 26) ? 1'b0 : x[kk];
  endfunction

  // a hang far past the ~300 cycles of tests counts against the run
  initial
  begin
    #20000;
    mismatches++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    run = 1'b0;
    ext = '0;
    csel = '0;
    cuse = '0;
    mask = '0;
    dsel = '0;
    arith = '0;
    rchain = '0;
    preset = '0;
    ureg = '0;
    fall = 2'b00;
    pb = 1'b1;
    pick = '0;
    lchain = '0;
    mismatches = 0;
    checked = 0;
    seed = 15909;
    tick(2);
    #1;
    check({cclk, regq, act}, 0);
    tick(1);
    resetn <= 1'b1;
    // random lookups fed from external lines and an unused code
    for (int n = 0; n < 40; n++)
    begin
      tick(1);
      e = 26'($random(seed));
      cu = 10'($random(seed));
      ext <= e;
      cuse <= cu;
      ureg <= 10'($random(seed));
      for (int i = 0; i < 10; i++)
      begin
        mask[i] <= 16'($random(seed));
        for (int j = 0; j < 4; j++)
        begin
          k[i][j] = ($random(seed) & 32'h7FFF) % 27;
          dsel[i][j] <= (k[i][j] == 26) ? 6'h3C : 6'(k[i][j] + 4);
        end
      end
      tick(3);
      #1;
      for (int i = 0; i < 10; i++)
      begin
        ix = {line_val(k[i][3], e), line_val(k[i][2], e),
              line_val(k[i][1], e), line_val(k[i][0], e)};
        want[i] = mask[i][ix];
      end
      cnt = $countones(cu);
      check(comb, want);
      check(act, cnt);
    end
    // add and subtract with addnsub taken from an external line
    for (int n = 0; n < 12; n++)
    begin
      tick(1);
      a = 10'($random(seed));
      b = 10'($random(seed));
      ext <= {5'h00, 1'(n & 1), b, a};
      arith <= 10'h3FF;
      cuse <= 10'h200;
      csel[9] <= 6'h18;
      for (int i = 0; i < 10; i++)
      begin
        dsel[i][0] <= 6'(i + 4);
        dsel[i][1] <= 6'(i + 14);
      end
      tick(3);
      #1;
      sum = (n & 1) ? {1'b0, a} + {1'b0, ~b} + 11'h001 : a + b;
      check(comb, sum[9:0]);
      check(cout, sum[10]);
    end
    // gated clock from column 0, gate and clear from local lines
    tick(1);
    arith <= '0;
    cuse <= 10'h015;
    csel[0] <= 6'h00;
    csel[2] <= 6'h04;
    csel[4] <= 6'h06;
    dsel[0][0] <= 6'h05;
    mask[0] <= 16'hAAAA;
    rchain <= 10'h002;
    run <= 1'b1;
    ext <= 26'h3;
    tick(12);
    #1;
    check(regq[1:0], 2'b11);
    check(act, 3);
    tick(1);
    ext <= 26'h2;
    tick(4);
    ext <= 26'h0;
    tick(12);
    #1;
    check(regq[1:0], 2'b11);
    for (int n = 0; n < 3; n++)
    begin
      tick(1);
      #1;
      check(cclk[0], 1'b0);
    end
    tick(1);
    ext <= 26'h1;
    tick(12);
    #1;
    check(regq[1:0], 2'b00);
    // preset cell reads one under clear, plain cell reads zero
    tick(1);
    preset <= 10'h001;
    ext <= 26'h5;
    tick(4);
    #1;
    check(regq[1:0], 2'b01);
    // neighbour links and own feedback steer the lookups
    tick(1);
    ureg <= 10'h000;
    mask <= {10{16'hAAAA}};
    for (int i = 0; i < 10; i++)
      dsel[i][0] <= (i < 4) ? 6'(40 + i) :
                    (i < 8) ? 6'(46 + i) : 6'(22 + i);
    for (int n = 0; n < 4; n++)
    begin
      tick(1);
      #1;
      a = lnk_l;
      b = lnk_r;
      cu = link;
      tick(1);
      #1;
      want = {cu[1:0], b[3:0], a[3:0]};
      check(comb, want);
      check(link, want);
    end
    // pair 1 on falling edges for cell 2, chained lookups, no push-back
    tick(1);
    ext <= 26'h0B;
    cuse <= 10'h08F;
    csel[1] <= 6'h00;
    csel[3] <= 6'h07;
    csel[7] <= 6'h08;
    fall <= 2'b10;
    pick <= 10'h004;
    pb <= 1'b0;
    preset <= 10'h001;
    rchain <= 10'h000;
    lchain <= 10'h060;
    ureg <= 10'h3FF;
    mask <= {{3{16'hAAAA}}, {2{16'hFF00}}, {5{16'hAAAA}}};
    for (int i = 0; i < 10; i++)
      dsel[i][0] <= 6'h05;
    tick(12);
    #1;
    check(regq, 10'h3FF);
    check(comb, 10'h3FF);
    check(link, 10'h3FF);
    check(act, 5);
    // closed pair 1 parks high and holds cell 2 while pair 0 runs on
    tick(1);
    ext <= 26'h03;
    tick(4);
    ext <= 26'h01;
    tick(12);
    #1;
    check(regq, 10'h004);
    check(comb, 10'h000);
    check(cclk[1], 1'b1);
    // one-cycle async load sets the preset cell without push-back
    tick(1);
    ext <= 26'h11;
    tick(1);
    ext <= 26'h01;
    tick(1);
    #1;
    check(regq[0], 1'b1);
    conclude();
  end
endmodule // tb_top
